// ===== hw/seq_defs.svh
// constants for the reset and startup sequencer
// assumes: included by bare name from every design file that needs it
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define CLK_PERIOD_NS 100
`define START_WAIT_BASE 256
`define START_WAIT_EXTRA 44
`define CHOP_FIRST_EXTRA 44
`define RESET_CMD_CODE 16'h0011
`define FRAME_WORDS 4'hA
`define FAST_SAMPLES 2'h2
`define PWR_MODE_DEFAULT 2'h2
`define CNT_W 16
`endif

// ===== hw/seq_pkg.sv
// types shared by the sequencer and its sample buffer
// assumes: nothing beyond a SystemVerilog compiler
package seq_pkg;
  typedef enum logic [3:0] {
    ST_POR = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_START = 4'b0100,
    ST_RUN = 4'b1000
  } seq_state_type;

  typedef struct packed {
    logic from_fast;
    logic chop_pol;
    logic [23:0] data;
  } sample_type;
endpackage : seq_pkg

// ===== hw/sample_fifo_if.sv
// carrier between the sequencer and its sample buffer
// assumes: one clock domain, all signals synchronous to it
`timescale 1ns/100ps
interface sample_fifo_if #(parameter int WIDTH = 26);
  logic flush;
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport producer (output flush, output wr_valid, input wr_ready, output wr_data,
                    input rd_valid, output rd_ready, input rd_data);
  modport buffer (input flush, input wr_valid, output wr_ready, input wr_data,
                  output rd_valid, input rd_ready, output rd_data);
endinterface : sample_fifo_if

// ===== hw/sample_fifo.sv
// flip-flop sample buffer with valid/ready on both sides
// assumes: depth is a power of two, flush is synchronous
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  sample_fifo_if.buffer port
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("sample_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic do_wr;
  logic do_rd;

  // full when pointers differ only in the wrap bit
  assign port.wr_ready = (wr_ptr_q ^ rd_ptr_q) != {1'b1, {AW{1'b0}}};
  assign port.rd_valid = wr_ptr_q != rd_ptr_q;
  assign port.rd_data = mem_q[rd_ptr_q[AW-1:0]];
  assign do_wr = port.wr_valid & port.wr_ready;
  assign do_rd = port.rd_valid & port.rd_ready;

  // pointers; flush empties without touching storage
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else if (port.flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_rd)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_ref_clk)
  begin
    if (do_wr)
      mem_q[wr_ptr_q[AW-1:0]] <= port.wr_data;
  end
endmodule : sample_fifo

// ===== hw/adc_reset_startup_sequencer.sv
// reset, startup and conversion-mode sequencer of the converter
// assumes: i_ref_clk 10 MHz; pin and external clock are asynchronous;
// serial words and filter results come from logic on i_ref_clk
`timescale 1ns/100ps
`include "seq_defs.svh"
module adc_reset_startup_sequencer import seq_pkg::*; #(
  parameter int POR_WAIT_NS = 200000,
  parameter int LOW_MIN_NS = 2000,
  parameter int SETTLE_NS = 5000,
  parameter int OVERSAMPLING_RATIO = 1024,
  parameter int CHOP_DELAY = 2,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_sync_rst_pin_n,
  input wire logic i_ext_clock_in,
  input wire logic i_word_valid,
  input wire logic [15:0] i_word,
  input wire logic i_frame_end,
  input wire logic i_global_chop,
  input wire logic [1:0] i_power_mode,
  input wire logic [23:0] i_fast_result,
  input wire logic [23:0] i_sinc3_result,
  input wire logic i_sample_ready,
  output logic o_ready_strobe_n,
  output logic o_serial_enable,
  output logic o_load_defaults,
  output logic o_mod_run,
  output logic o_fast_filter_en,
  output logic o_chop_polarity,
  output logic [1:0] o_power_mode,
  output logic o_sample_valid,
  output logic [23:0] o_sample_data,
  output logic o_sample_fast
);
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int POR_CYC = (POR_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int LOW_MIN_CYC = (LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int START_TICKS = `START_WAIT_BASE + `START_WAIT_EXTRA;
  localparam int CHOP_PERIOD = CHOP_DELAY + 3 * OVERSAMPLING_RATIO;
  localparam int CHOP_FIRST = 2 * CHOP_PERIOD + `CHOP_FIRST_EXTRA;
  localparam int SW = $bits(sample_type);

  if (POR_CYC < 1 || LOW_MIN_CYC < 4 || SETTLE_CYC < 1 || OVERSAMPLING_RATIO < 4 ||
      CHOP_FIRST >= (1 << `CNT_W) || POR_CYC >= (1 << `CNT_W) || FIFO_DEPTH < 2)
  begin : g_bad_param
    $error("sequencer parameters out of range");
  end

  // modulator ticks per output sample for the present mode
  function automatic logic [`CNT_W-1:0] period_len(input logic chop, input logic first);
    logic [`CNT_W-1:0] len;
    len = `CNT_W'(OVERSAMPLING_RATIO);
    if (chop)
      len = first ? `CNT_W'(CHOP_FIRST) : `CNT_W'(CHOP_PERIOD);
    return len;
  endfunction : period_len

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic pin_s1_q;
  logic pin_s2_q;
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  logic mod_tick;

  // two flops for the pin, three for the clock; the edge detector reads only the second and third
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= i_sync_rst_pin_n;
      pin_s2_q <= pin_s1_q;
      clk_s1_q <= i_ext_clock_in;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  // one enable pulse per modulator period; no pulse while the clock stands
  assign mod_tick = clk_s2_q & ~clk_s3_q;

  // ****************************************************************
  // reset sources
  // ****************************************************************
  logic [`CNT_W-1:0] low_cnt_q;
  logic pin_reset;
  logic [3:0] word_cnt_q;
  logic cmd_pend_q;
  logic cmd_fire;
  logic ready_q;

  // low-time filter: a short glitch never reaches the count limit
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      low_cnt_q <= '0;
    else if (pin_s2_q)
      low_cnt_q <= '0;
    else if (low_cnt_q != `CNT_W'(LOW_MIN_CYC))
      low_cnt_q <= low_cnt_q + 1'b1;
  end

  assign pin_reset = ~pin_s2_q & (low_cnt_q == `CNT_W'(LOW_MIN_CYC));

  // frame word counter; words are dropped while the port is not ready
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      word_cnt_q <= '0;
      cmd_pend_q <= 1'b0;
    end
    else if (i_frame_end || pin_reset)
    begin
      word_cnt_q <= '0;
      cmd_pend_q <= 1'b0;
    end
    else if (i_word_valid && ready_q)
    begin
      if (word_cnt_q == 4'h0)
        cmd_pend_q <= (i_word == `RESET_CMD_CODE);
      if (word_cnt_q != `FRAME_WORDS)
        word_cnt_q <= word_cnt_q + 1'b1;
    end
  end

  // command acts only on the closing edge of a full ten-word frame
  assign cmd_fire = i_frame_end & cmd_pend_q & (word_cnt_q == `FRAME_WORDS);

  // ****************************************************************
  // sequence state
  // ****************************************************************
  seq_state_type state_q;
  logic [`CNT_W-1:0] wait_cnt_q;
  logic [`CNT_W-1:0] tick_cnt_q;
  logic [1:0] sample_idx_q;
  logic first_q;
  logic chop_pol_q;
  logic period_done;
  logic push;
  sample_type push_word;
  sample_fifo_if #(.WIDTH(SW)) fifo ();

  assign period_done = (state_q == ST_RUN) && mod_tick &&
                       (tick_cnt_q == period_len(i_global_chop, first_q) - 1'b1);
  // a full buffer stalls the sample counter at its last tick
  assign push = (state_q == ST_RUN) && (tick_cnt_q == period_len(i_global_chop, first_q)) &&
                fifo.wr_ready;

  // main sequence: power-on wait, pin hold, start delay, converting
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state_q <= ST_POR;
    else if (pin_reset)
      state_q <= ST_HOLD;
    else if (cmd_fire)
      state_q <= ST_START;
    else
    begin
      case (state_q)
        ST_POR:
          if (wait_cnt_q == `CNT_W'(POR_CYC - 1))
            state_q <= ST_START;
        ST_HOLD:
          if (pin_s2_q)
            state_q <= ST_START;
        ST_START:
          if (mod_tick && tick_cnt_q == `CNT_W'(START_TICKS - 1))
            state_q <= ST_RUN;
        ST_RUN:
          state_q <= ST_RUN;
        default:
          state_q <= ST_POR;
      endcase
    end
  end

  // wall-clock wait: power-on interval, then settle time after other resets
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      wait_cnt_q <= '0;
    else if (pin_reset || cmd_fire || (state_q == ST_HOLD))
      wait_cnt_q <= '0;
    else if (!ready_q)
      wait_cnt_q <= wait_cnt_q + 1'b1;
  end

  // serial port ready flag: cleared by every reset, set when the wait ends
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      ready_q <= 1'b0;
    else if (pin_reset || cmd_fire || (state_q == ST_HOLD))
      ready_q <= 1'b0;
    else if (state_q == ST_POR && wait_cnt_q == `CNT_W'(POR_CYC - 1))
      ready_q <= 1'b1;
    else if (state_q != ST_POR && wait_cnt_q == `CNT_W'(SETTLE_CYC - 1))
      ready_q <= 1'b1;
  end

  // modulator tick counter for the start delay and each sample period
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      tick_cnt_q <= '0;
    else if (pin_reset || cmd_fire || state_q == ST_POR || state_q == ST_HOLD)
      tick_cnt_q <= '0;
    else if (state_q == ST_START && mod_tick)
      tick_cnt_q <= (tick_cnt_q == `CNT_W'(START_TICKS - 1)) ? '0 : tick_cnt_q + 1'b1;
    else if (push)
      tick_cnt_q <= '0;
    else if (period_done || (state_q == ST_RUN && mod_tick &&
             tick_cnt_q != period_len(i_global_chop, first_q)))
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  // sample index picks fast filter for the first two outputs when chop is off
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sample_idx_q <= '0;
      first_q <= 1'b1;
      chop_pol_q <= 1'b0;
    end
    else if (pin_reset || cmd_fire || state_q != ST_RUN)
    begin
      sample_idx_q <= '0;
      first_q <= 1'b1;
      chop_pol_q <= 1'b0;
    end
    else if (push)
    begin
      first_q <= 1'b0;
      if (sample_idx_q != `FAST_SAMPLES)
        sample_idx_q <= sample_idx_q + 1'b1;
      if (i_global_chop)
        chop_pol_q <= ~chop_pol_q;
    end
  end

  // ****************************************************************
  // sample path and outputs
  // ****************************************************************
  // chop results are averaged pairs, so they never take the fast path
  always_comb
  begin
    push_word.from_fast = (sample_idx_q < `FAST_SAMPLES) && !i_global_chop;
    push_word.chop_pol = chop_pol_q;
    push_word.data = push_word.from_fast ? i_fast_result : i_sinc3_result;
  end

  assign fifo.flush = pin_reset | cmd_fire;
  assign fifo.wr_valid = push;
  assign fifo.wr_data = push_word;
  assign fifo.rd_ready = i_sample_ready;

  sample_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .port(fifo)
  );

  // ready strobe: low in reset, falls per sample, high again once drained
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_ready_strobe_n <= 1'b0;
    else if (!ready_q || pin_reset || cmd_fire)
      o_ready_strobe_n <= 1'b0;
    else if (push)
      o_ready_strobe_n <= 1'b0;
    else if (!fifo.rd_valid)
      o_ready_strobe_n <= 1'b1;
  end

  // status flops seen by the rest of the converter
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_load_defaults <= 1'b1;
      o_mod_run <= 1'b0;
      o_fast_filter_en <= 1'b1;
      o_chop_polarity <= 1'b0;
      o_power_mode <= `PWR_MODE_DEFAULT;
    end
    else
    begin
      o_load_defaults <= pin_reset | cmd_fire | (state_q == ST_POR) | (state_q == ST_HOLD);
      o_mod_run <= (state_q == ST_RUN);
      o_fast_filter_en <= (sample_idx_q < `FAST_SAMPLES) && !i_global_chop;
      o_chop_polarity <= chop_pol_q;
      o_power_mode <= (pin_reset | cmd_fire) ? `PWR_MODE_DEFAULT : i_power_mode;
    end
  end

  assign o_serial_enable = ready_q;
  assign o_sample_valid = fifo.rd_valid;
  assign o_sample_data = fifo.rd_data[23:0];
  assign o_sample_fast = fifo.rd_data[SW-1];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  property p_hold_low;
    (state_q == ST_HOLD) && !pin_s2_q |=> !o_ready_strobe_n && !o_serial_enable;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("ready not held low during pin reset");

  property p_ignore_words;
    !ready_q && i_word_valid && !i_frame_end && !pin_reset |=> $stable(word_cnt_q);
  endproperty
  a_ignore_words: assert property (p_ignore_words) else $error("word taken before ready");

  property p_short_frame;
    i_frame_end && (word_cnt_q != `FRAME_WORDS) |-> !cmd_fire;
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame caused a reset");

  property p_cmd_reset;
    cmd_fire && !pin_reset |=> (state_q == ST_START) && !ready_q ##1 !o_ready_strobe_n;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset) else $error("command did not reset");

  property p_short_pulse;
    ready_q && pin_s2_q ##1 !pin_s2_q [*3] ##1 pin_s2_q |-> ready_q;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pin pulse reset the device");

  property p_start_delay;
    (state_q == ST_RUN) && ($past(state_q) == ST_START) |-> $past(tick_cnt_q) == `CNT_W'(START_TICKS - 1);
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("modulators started early");

  property p_fast_first;
    push && !i_global_chop |-> fifo.wr_data[SW-1] == (sample_idx_q != `FAST_SAMPLES);
  endproperty
  a_fast_first: assert property (p_fast_first) else $error("wrong filter for sample");

  // a ready consumer pops the head one edge after the push, so valid is checked together with the strobe
  property p_strobe_fall;
    push && ready_q && !cmd_fire && !pin_reset |=> !o_ready_strobe_n && o_sample_valid;
  endproperty
  a_strobe_fall: assert property (p_strobe_fall) else $error("no ready fall for new sample");

  property p_ready_rise;
    $rose(ready_q) && !fifo.rd_valid |=> o_ready_strobe_n;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready strobe did not rise");

  c_cmd_reset: cover property (cmd_fire);
  c_pin_reset: cover property (pin_reset ##[1:100] pin_s2_q);
  c_sinc3_sample: cover property (push && !fifo.wr_data[SW-1]);
  c_chop_swap: cover property (push && i_global_chop && chop_pol_q);
endmodule : adc_reset_startup_sequencer

// ===== test/host_model.sv
// host-side partner: modulator clock source and serial frame sender
// assumes: bench gates the clock and calls send_frame both before and after ready
`timescale 1ns/100ps
module host_model (
  input wire logic i_ref_clk,
  input wire logic i_clk_run,
  output logic o_ext_clock,
  output logic o_word_valid,
  output logic [15:0] o_word,
  output logic o_frame_end
);
  // 800 ns clock, phase unrelated to i_ref_clk; stands still while stopped
  initial
  begin
    o_ext_clock = 1'b0;
    o_word_valid = 1'b0;
    o_word = 16'h0000;
    o_frame_end = 1'b0;
    #137;
    forever
    begin
      #400;
      o_ext_clock = i_clk_run ? ~o_ext_clock : 1'b0;
    end
  end

  // n words back to back; idle word is the inverse so nothing stale lingers
  task automatic send_frame(input int n, input logic [15:0] first);
    for (int k = 0; k < n; k++)
    begin
      @(posedge i_ref_clk);
      o_word_valid <= 1'b1;
      o_word <= (k == 0) ? first : 16'h00F0 + 16'(k);
    end
    @(posedge i_ref_clk);
    o_word_valid <= 1'b0;
    o_word <= ~o_word;
    o_frame_end <= 1'b1;
    @(posedge i_ref_clk);
    o_frame_end <= 1'b0;
  endtask : send_frame
endmodule : host_model

// ===== test/test_adc_reset_startup_sequencer.sv
// self-checking bench for the reset and startup sequencer
// assumes: host_model compiled first; shortened time parameters below
`timescale 1ns/100ps
module test_adc_reset_startup_sequencer;
  import seq_pkg::*;
  localparam int POR_CYC = 20;
  localparam int TICK = 8;
  localparam int RATIO = 8;
  localparam logic [23:0] FAST_VAL = 24'hA5A5A5;
  localparam logic [23:0] SINC_VAL = 24'h5C3C3C;
  logic i_ref_clk, i_reset, i_sync_rst_pin_n, i_global_chop, i_sample_ready, clk_run;
  logic ext_clk, word_valid, frame_end;
  logic [15:0] word;
  logic [1:0] i_power_mode;
  logic o_ready_strobe_n, o_serial_enable, o_load_defaults, o_mod_run, o_fast_filter_en;
  logic o_chop_polarity, o_sample_valid, o_sample_fast;
  logic [1:0] o_power_mode;
  logic [23:0] o_sample_data;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

`define CHECK(got, exp, msg) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("MISMATCH %0t %s", $time, msg); \
    end \
  end

  host_model i_host (.i_ref_clk(i_ref_clk), .i_clk_run(clk_run), .o_ext_clock(ext_clk),
    .o_word_valid(word_valid), .o_word(word), .o_frame_end(frame_end));

  adc_reset_startup_sequencer #(.POR_WAIT_NS(2000), .LOW_MIN_NS(500), .SETTLE_NS(500),
    .OVERSAMPLING_RATIO(RATIO)) i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_sync_rst_pin_n(i_sync_rst_pin_n), .i_ext_clock_in(ext_clk), .i_word_valid(word_valid),
    .i_word(word), .i_frame_end(frame_end), .i_global_chop(i_global_chop),
    .i_power_mode(i_power_mode), .i_fast_result(FAST_VAL), .i_sinc3_result(SINC_VAL),
    .i_sample_ready(i_sample_ready), .o_ready_strobe_n(o_ready_strobe_n),
    .o_serial_enable(o_serial_enable), .o_load_defaults(o_load_defaults), .o_mod_run(o_mod_run),
    .o_fast_filter_en(o_fast_filter_en), .o_chop_polarity(o_chop_polarity),
    .o_power_mode(o_power_mode), .o_sample_valid(o_sample_valid), .o_sample_data(o_sample_data),
    .o_sample_fast(o_sample_fast));

  // 10 MHz clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever
    begin
      #50 i_ref_clk = ~i_ref_clk;
    end
  end

  // cycle count and hang guard, well above the ~10k cycles the run needs
  always @(posedge i_ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step

  // bounded wait for the serial port to report ready
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (!(o_serial_enable === 1'b1 && o_ready_strobe_n === 1'b1) && cnt < 200)
    begin
      step(1);
      cnt++;
    end
    `CHECK(o_ready_strobe_n, 1'b1, "ready never rose");
  endtask : wait_ready

  // waits for the next sample; consumer is always ready, so it pops here
  task automatic wait_sample(input logic fast);
    int n;
    n = 0;
    while (o_sample_valid !== 1'b1 && n < 5000)
    begin
      step(1);
      n++;
    end
    `CHECK(o_sample_valid, 1'b1, "no sample");
    `CHECK(o_sample_fast, fast, "filter path");
    `CHECK(o_sample_data, fast ? FAST_VAL : SINC_VAL, "sample data");
    `CHECK(o_ready_strobe_n, 1'b0, "strobe low on sample");
    step(1);
  endtask : wait_sample

  // pin low for len cycles, driven on the clock edge
  task automatic pin_pulse(input int len);
    @(posedge i_ref_clk);
    i_sync_rst_pin_n <= 1'b0;
    repeat (len) @(posedge i_ref_clk);
    i_sync_rst_pin_n <= 1'b1;
    #1;
  endtask : pin_pulse

  // power-on wait, early frame ignored, power mode default and follow
  task automatic t_power_on();
    int cnt;
    fork
      i_host.send_frame(10, 16'h0011);
      step(10);
    join
    // the frame task returns on a clock edge; let the outputs settle first
    #1;
    `CHECK(o_ready_strobe_n, 1'b0, "ready early");
    `CHECK(o_load_defaults, 1'b1, "defaults not loading");
    `CHECK(o_power_mode, 2'h2, "power mode default");
    wait_ready(cnt);
    `CHECK(cnt >= POR_CYC - 12 && cnt <= POR_CYC - 8, 1'b1, "power-on wait length");
    step(10);
    `CHECK(o_serial_enable, 1'b1, "early frame acted on");
    i_power_mode <= 2'h1;
    step(3);
    `CHECK(o_power_mode, 2'h1, "power mode select");
  endtask : t_power_on

  // clock start, start delay, fast then sinc3 samples, data rate
  task automatic t_startup();
    int t0;
    int t1;
    t0 = cycles;
    clk_run <= 1'b1;
    while (o_mod_run !== 1'b1 && cycles - t0 < 3000)
      step(1);
    `CHECK((cycles - t0) >= 2380 && (cycles - t0) <= 2420, 1'b1, "start delay");
    wait_sample(1'b1);
    `CHECK((cycles - t0) >= 2444 && (cycles - t0) <= 2484, 1'b1, "first sample time");
    t1 = cycles;
    wait_sample(1'b1);
    `CHECK(cycles - t1 >= RATIO * TICK - 2 && cycles - t1 <= RATIO * TICK + 2, 1'b1, "rate");
    wait_sample(1'b0);
    `CHECK(o_fast_filter_en, 1'b0, "fast filter still on");
  endtask : t_startup

  // consumer stalls until the buffer refuses, then drains it
  task automatic t_fifo_fill();
    int n;
    n = 0;
    i_sample_ready <= 1'b0;
    step(20 * RATIO * TICK);
    `CHECK(o_ready_strobe_n, 1'b0, "strobe while unread");
    i_sample_ready <= 1'b1;
    repeat (16)
    begin
      step(1);
      n += (o_sample_valid === 1'b1) ? 1 : 0;
    end
    `CHECK(n, 16, "buffer depth");
  endtask : t_fifo_fill

  task automatic t_short_pulse();
    pin_pulse(3);
    step(12);
    `CHECK(o_serial_enable, 1'b1, "short pulse reset");
    `CHECK(o_mod_run, 1'b1, "short pulse stopped modulators");
  endtask : t_short_pulse

  // early-ended frame, plain frame, then a full reset frame
  task automatic t_command();
    int cnt;
    i_host.send_frame(5, 16'h0011);
    step(4);
    `CHECK(o_serial_enable, 1'b1, "short frame acted on");
    i_host.send_frame(10, 16'h0000);
    step(4);
    `CHECK(o_serial_enable, 1'b1, "plain frame reset");
    i_host.send_frame(10, 16'h0011);
    step(2);
    `CHECK(o_serial_enable, 1'b0, "command reset missing");
    `CHECK(o_mod_run, 1'b0, "modulators not reset");
    wait_ready(cnt);
    `CHECK(cnt <= 12, 1'b1, "command settle too long");
  endtask : t_command

  // long pin low holds reset; restart without power-on wait
  task automatic t_pin_reset(input logic chop);
    int cnt;
    logic pol;
    i_global_chop <= chop;
    fork
      pin_pulse(30);
      begin
        step(20);
        `CHECK(o_serial_enable, 1'b0, "pin reset missing");
        `CHECK(o_load_defaults, 1'b1, "defaults during hold");
        `CHECK(o_ready_strobe_n, 1'b0, "strobe during hold");
        `CHECK(o_mod_run, 1'b0, "modulators during hold");
      end
    join
    wait_ready(cnt);
    `CHECK(cnt <= 12, 1'b1, "pin settle too long");
    wait_sample(!chop);
    pol = o_chop_polarity;
    wait_sample(!chop);
    if (chop)
      `CHECK(o_chop_polarity, ~pol, "chop polarity swap");
    wait_sample(1'b0);
  endtask : t_pin_reset

  // main sequence
  initial
  begin
    i_reset = 1'b1;
    i_sync_rst_pin_n = 1'b1;
    i_global_chop = 1'b0;
    i_power_mode = 2'h2;
    i_sample_ready = 1'b1;
    clk_run = 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_power_on();
    t_startup();
    t_fifo_fill();
    t_short_pulse();
    t_command();
    t_pin_reset(1'b0);
    t_pin_reset(1'b1);
    give_verdict();
  end
endmodule : test_adc_reset_startup_sequencer
